// [design/pbvt_top.sv]
// Push-button channel: scene with memory and temperature value transmitter
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module pbvt_top #(
    parameter int CYC_PER_MS = pbvt_pkg::CYC_PER_MS_DEF
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins
    input wire logic contact,
    input wire logic bus_present,
    // Function and edge configuration
    input wire logic mode_temp,
    input wire logic [1:0] edge_sel,
    // Scene configuration
    input wire logic [pbvt_pkg::DATA_W-1:0] scene_rise,
    input wire logic [pbvt_pkg::DATA_W-1:0] scene_fall,
    input wire logic store_only,
    input wire logic [1:0] store_base,
    input wire logic [pbvt_pkg::FAC_W-1:0] store_factor,
    // Temperature configuration
    input wire logic [pbvt_pkg::DATA_W-1:0] temp_rise,
    input wire logic [pbvt_pkg::DATA_W-1:0] temp_fall,
    input wire logic adj_en,
    input wire logic [1:0] adj_base,
    input wire logic [pbvt_pkg::FAC_W-1:0] adj_factor,
    // Bus return configuration
    input wire logic [1:0] ret_react,
    input wire logic [pbvt_pkg::MS_W-1:0] ret_delay_ms,
    // Telegram out
    output logic tx_valid,
    output logic [1:0] tx_kind,
    output logic [pbvt_pkg::DATA_W-1:0] tx_data,
    // Status
    output logic tx_btn,
    output logic [pbvt_pkg::DATA_W-1:0] cur_value,
    output logic busy
);
    import pbvt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic logic [MS_W-1:0] f_iv(
        input logic [1:0] sel,
        input logic [FAC_W-1:0] fac,
        input logic [FAC_W-1:0] fmin
    );
        logic [FAC_W-1:0] f;
        logic [MS_W-1:0] b;
        f = (fac < fmin) ? fmin : fac;
        case (sel)
            2'h0: b = BASE0_MS;
            2'h1: b = BASE1_MS;
            2'h2: b = BASE2_MS;
            default: b = BASE3_MS;
        endcase
        f_iv = MS_W'(b * f);
    endfunction

    function automatic logic [DATA_W-1:0] f_clamp(input logic [DATA_W-1:0] v);
        f_clamp = (v > TEMP_MAX) ? TEMP_MAX : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic c_lvl;
    logic c_rise;
    logic c_fall;
    logic b_rise;

    pbvt_sync u_contact (
        .clock(clock),
        .rst_n(rst_n),
        .pin(contact),
        .level(c_lvl),
        .rise(c_rise),
        .fall(c_fall)
    );

    // A bus already present at reset release also counts as a return
    pbvt_sync u_bus (
        .clock(clock),
        .rst_n(rst_n),
        .pin(bus_present),
        .level(),
        .rise(b_rise),
        .fall()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Actuation decode

    logic both;
    logic fall_only;
    logic hit;
    logic act_lvl;
    logic [DATA_W-1:0] t_rise;
    logic [DATA_W-1:0] t_fall;

    assign both = (edge_sel == EDGE_BOTH);
    assign fall_only = (edge_sel == EDGE_FALL);
    assign t_rise = f_clamp(temp_rise);
    assign t_fall = f_clamp(temp_fall);

    // edge that starts an actuation; scene mode has no switch option
    assign hit = fall_only ? c_fall : (both && mode_temp) ? (c_rise || c_fall) : c_rise;
    // Pressed level follows the contact type
    assign act_lvl = fall_only ? !c_lvl : c_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // Long-press timer

    pbvt_state_e state;
    pbvt_state_e next_state;
    logic tmr_run;
    logic tmr_exp;
    logic [MS_W-1:0] tmr_iv;

    assign tmr_run = (state == ST_HOLD) || (state == ST_ADJ);
    assign tmr_iv = mode_temp ? f_iv(adj_base, adj_factor, ADJ_FAC_MIN)
                              : f_iv(store_base, store_factor, STORE_FAC_MIN);

    pbvt_timer #(.CYC_PER_MS(CYC_PER_MS)) u_press (
        .clock(clock),
        .rst_n(rst_n),
        .run(tmr_run),
        .interval_ms(tmr_iv),
        .expire(tmr_exp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Adjustment step

    logic cur_ok;
    logic dir_up;
    logic [DATA_W-1:0] cur_val;
    logic [DATA_W-1:0] step_val;
    logic step_up;

    // one kelvin per step, turning round at the range ends
    always_comb begin
        step_up = dir_up;
        if (dir_up && cur_val >= TEMP_MAX) begin
            step_up = 1'b0;
        end else if (!dir_up && cur_val == TEMP_MIN) begin
            step_up = 1'b1;
        end
        step_val = step_up ? DATA_W'(cur_val + TEMP_STEP) : DATA_W'(cur_val - TEMP_STEP);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Press sequencer

    logic btn_tx;
    logic [1:0] btn_kind;
    logic [DATA_W-1:0] btn_data;
    logic [DATA_W-1:0] next_val;
    logic next_dir;
    logic [DATA_W-1:0] scene;

    // scene number for the selected edge
    assign scene = fall_only ? scene_fall : scene_rise;

    always_comb begin
        next_state = state;
        btn_tx = 1'b0;
        btn_kind = KIND_VALUE;
        btn_data = cur_val;
        next_val = cur_val;
        next_dir = dir_up;
        case (state)
            ST_IDLE: begin
                if (hit) begin
                    btn_tx = 1'b1;
                    if (!mode_temp) begin
                        btn_data = scene;
                        btn_kind = store_only ? KIND_STORE : KIND_RECALL;
                        if (!store_only) begin
                            next_state = ST_HOLD;
                        end
                    end else if (both) begin
                        // switch sends the value of the edge seen
                        btn_data = c_rise ? t_rise : t_fall;
                    end else if (adj_en) begin
                        // only then does the cyclic timer run
                        next_state = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                if (!act_lvl) begin
                    // early release ends with the first telegram alone (recall in scene mode, value in temperature mode)
                    next_state = ST_IDLE;
                end else if (tmr_exp) begin
                    btn_tx = 1'b1;
                    if (!mode_temp) begin
                        // held long enough for a store
                        btn_kind = KIND_STORE;
                        btn_data = scene;
                        next_state = ST_DONE;
                    end else begin
                        btn_data = step_val;
                        next_val = step_val;
                        next_dir = step_up;
                        next_state = ST_ADJ;
                    end
                end
            end
            ST_ADJ: begin
                if (!act_lvl) begin
                    // Next long press runs the other way
                    next_dir = !dir_up;
                    next_state = ST_IDLE;
                end else if (tmr_exp) begin
                    btn_tx = 1'b1;
                    btn_data = step_val;
                    next_val = step_val;
                    next_dir = step_up;
                end
            end
            ST_DONE: begin
                if (!act_lvl) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // adjusted value is kept; first loaded after reset release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_ok <= 1'b0;
            cur_val <= TEMP_MIN;
            dir_up <= 1'b0;
        end else if (!cur_ok) begin
            cur_ok <= 1'b1;
            cur_val <= fall_only ? t_fall : t_rise;
        end else begin
            cur_val <= next_val;
            dir_up <= next_dir;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus voltage return

    logic ret_wait;
    logic ret_exp;
    logic ret_pend;
    logic ret_ok;
    logic ret_hi;
    logic [DATA_W-1:0] ret_data;

    pbvt_timer #(.CYC_PER_MS(CYC_PER_MS)) u_return (
        .clock(clock),
        .rst_n(rst_n),
        .run(ret_wait),
        .interval_ms(ret_delay_ms),
        .expire(ret_exp)
    );

    // edge reactions need a compatible edge selection
    always_comb begin
        ret_ok = 1'b0;
        ret_hi = 1'b1;
        case (ret_react)
            RET_RISE: ret_ok = (edge_sel != EDGE_FALL);
            RET_FALL: begin
                ret_ok = (edge_sel != EDGE_RISE);
                ret_hi = 1'b0;
            end
            RET_CUR: begin
                // level picks the matching edge value
                ret_ok = mode_temp && both;
                ret_hi = c_lvl;
            end
            default: ret_ok = 1'b0;
        endcase
    end

    assign ret_data = mode_temp ? (ret_hi ? t_rise : t_fall)
                                : (ret_hi ? scene_rise : scene_fall);

    // reaction only after the delay; a button telegram goes first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ret_wait <= 1'b0;
            ret_pend <= 1'b0;
        end else begin
            if (b_rise) begin
                ret_wait <= 1'b1;
            end else if (ret_exp) begin
                ret_wait <= 1'b0;
            end
            if (ret_exp && ret_ok) begin
                ret_pend <= 1'b1;
            end else if (!btn_tx) begin
                ret_pend <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Telegram register

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_btn <= 1'b0;
            tx_kind <= KIND_RECALL;
            tx_data <= TEMP_MIN;
        end else begin
            tx_valid <= btn_tx || ret_pend;
            tx_btn <= btn_tx;
            if (btn_tx) begin
                tx_kind <= btn_kind;
                tx_data <= btn_data;
            end else if (ret_pend) begin
                tx_kind <= mode_temp ? KIND_VALUE : KIND_RECALL;
                tx_data <= ret_data;
            end
        end
    end

    assign cur_value = cur_val;
    assign busy = (state != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_idle_needs_edge: assert property (
        state == ST_IDLE && !hit |=> state == ST_IDLE)
        else $error("actuation began without a selected edge");

    a_rise_scene_sel: assert property (
        tx_valid && tx_btn && !mode_temp && edge_sel == EDGE_RISE |-> tx_data == scene_rise)
        else $error("rising actuation sent the wrong scene");

    a_fall_scene_sel: assert property (
        tx_valid && tx_btn && !mode_temp && fall_only |-> tx_data == scene_fall)
        else $error("falling actuation sent the wrong scene");

    a_store_only_kind: assert property (
        store_only && !mode_temp && tx_valid && tx_btn |-> tx_kind == KIND_STORE)
        else $error("store-only sent a recall");

    a_store_on_expiry: assert property (
        state == ST_HOLD && !mode_temp && act_lvl && tmr_exp
        |=> tx_valid && tx_kind == KIND_STORE ##1 state == ST_DONE || !act_lvl)
        else $error("long press did not store");

    a_release_no_store: assert property (
        state == ST_HOLD && !act_lvl |=> state == ST_IDLE && !(tx_btn && tx_kind == KIND_STORE))
        else $error("store sent after early release");

    a_return_after_delay: assert property (
        $rose(ret_pend) |-> $past(ret_exp) && $past(ret_ok))
        else $error("return reaction ran before the delay");

    a_step_one_kelvin: assert property (
        state == ST_ADJ && $changed(cur_val)
        |-> cur_val == DATA_W'($past(cur_val) + TEMP_STEP)
            || DATA_W'(cur_val + TEMP_STEP) == $past(cur_val))
        else $error("adjustment step not one kelvin");

    a_value_in_range: assert property (
        tx_valid && mode_temp |-> tx_data <= TEMP_MAX)
        else $error("temperature out of range");

    a_adj_single_edge: assert property (
        state == ST_ADJ |-> !both && mode_temp)
        else $error("adjustment in switch mode");

    c_store_sent: cover property (tx_valid && tx_btn && tx_kind == KIND_STORE);
    c_adj_step: cover property (state == ST_ADJ && tx_valid);
    c_return_sent: cover property (tx_valid && !tx_btn);
    c_early_release: cover property (state == ST_HOLD ##1 state == ST_IDLE);
endmodule
`default_nettype wire

// [design/pbvt_pkg.sv]
// Shared constants and types for the push-button value transmitter
package pbvt_pkg;
    // Clock rate and the millisecond tick derived from it
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 1000;
    localparam int CYC_PER_MS_DEF = CLK_MHZ * TICK_US;

    // Widths
    localparam int MS_W = 17;
    localparam int DATA_W = 7;
    localparam int FAC_W = 7;

    // Actuation edge selection
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // Reaction after bus voltage return
    localparam logic [1:0] RET_NONE = 2'h0;
    localparam logic [1:0] RET_RISE = 2'h1;
    localparam logic [1:0] RET_FALL = 2'h2;
    localparam logic [1:0] RET_CUR = 2'h3;

    // Telegram kinds
    localparam logic [1:0] KIND_RECALL = 2'h0;
    localparam logic [1:0] KIND_STORE = 2'h1;
    localparam logic [1:0] KIND_VALUE = 2'h2;

    // Time bases in ms: 130, 260, 520, 1000
    localparam logic [MS_W-1:0] BASE0_MS = 17'h00082;
    localparam logic [MS_W-1:0] BASE1_MS = 17'h00104;
    localparam logic [MS_W-1:0] BASE2_MS = 17'h00208;
    localparam logic [MS_W-1:0] BASE3_MS = 17'h003E8;
    localparam logic [MS_W-1:0] MS_ONE = 17'h00001;

    // Factor floors and temperature limits
    localparam logic [FAC_W-1:0] STORE_FAC_MIN = 7'h09;
    localparam logic [FAC_W-1:0] ADJ_FAC_MIN = 7'h03;
    localparam logic [DATA_W-1:0] TEMP_MAX = 7'h28;
    localparam logic [DATA_W-1:0] TEMP_MIN = 7'h00;
    localparam logic [DATA_W-1:0] TEMP_STEP = 7'h01;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_ADJ = 4'b0100,
        ST_DONE = 4'b1000
    } pbvt_state_e;
endpackage

// [design/pbvt_sync.sv]
// Two-stage synchroniser with edge pulses for a pin input
`timescale 1ns/1ps
`default_nettype none
module pbvt_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pin side
    input wire logic pin,
    // Synchronised level and edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic prev;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            level <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            level <= meta;
            prev <= level;
        end
    end

    // Edges look only at the second stage and its delayed copy
    assign rise = level && !prev;
    assign fall = !level && prev;
endmodule
`default_nettype wire

// [design/pbvt_timer.sv]
// Periodic millisecond interval timer with its own tick divider
`timescale 1ns/1ps
`default_nettype none
module pbvt_timer #(
    parameter int CYC_PER_MS = pbvt_pkg::CYC_PER_MS_DEF
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [pbvt_pkg::MS_W-1:0] interval_ms,
    // Event
    output logic expire
);
    import pbvt_pkg::*;

    localparam int DIV_W = $clog2(CYC_PER_MS + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_MS - 1);

    logic [DIV_W-1:0] div;
    logic [MS_W-1:0] ms;
    logic tick;

    assign tick = (div == DIV_LAST);

    // Idle clears everything so each run starts a full interval
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div <= '0;
            ms <= '0;
            expire <= 1'b0;
        end else if (!run) begin
            div <= '0;
            ms <= '0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            div <= tick ? '0 : DIV_W'(div + 1'b1);
            if (tick) begin
                if (MS_W'(ms + MS_ONE) >= interval_ms) begin
                    ms <= '0;
                    expire <= 1'b1;
                end else begin
                    ms <= MS_W'(ms + MS_ONE);
                end
            end
        end
    end

    a_expire_tick: assert property (@(posedge clock) disable iff (!rst_n)
        expire |-> $past(tick) && $past(run))
        else $error("timer expired off a millisecond tick");
endmodule
`default_nettype wire

// [bench/pbvt_bus_model.sv]
// Bus-side model: supplies bus voltage and logs up to 64 telegrams
`timescale 1ns/1ps
`default_nettype none
module pbvt_bus_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Telegrams from the channel
    input wire logic tx_valid,
    input wire logic [1:0] tx_kind,
    input wire logic [pbvt_pkg::DATA_W-1:0] tx_data,
    input wire logic tx_btn,
    // Bus voltage
    output var logic bus_present
);
    import pbvt_pkg::*;
    int cyc = 0;
    int n = 0;
    int rise_at = 0;
    logic [1:0] kind [64];
    logic [DATA_W-1:0] data [64];
    logic btn [64];
    int at [64];
    initial bus_present = 1'b0;
    // Log is capped so a runaway sender cannot overrun it
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (rst_n === 1'b1 && tx_valid === 1'b1 && n < 64) begin
            kind[n] <= tx_kind;
            data[n] <= tx_data;
            btn[n] <= tx_btn;
            at[n] <= cyc;
            n <= n + 1;
        end
    end
    task automatic bus_set(logic v);
        @(negedge clock);
        bus_present = v;
        rise_at = cyc;
    endtask
endmodule
`default_nettype wire

// [bench/pbvt_top_tb.sv]
// Self-checking testbench for the push-button value transmitter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module pbvt_top_tb;
    import pbvt_pkg::*;
    int comparisons = 0;
    int miscompares = 0;
    logic clock, rst_n, contact, bus_present, mode_temp, store_only, adj_en;
    logic [1:0] edge_sel, store_base, adj_base, ret_react;
    logic [DATA_W-1:0] scene_rise, scene_fall, temp_rise, temp_fall, tx_data, cur_value;
    logic [FAC_W-1:0] store_factor, adj_factor;
    logic [MS_W-1:0] ret_delay_ms;
    logic tx_valid, tx_btn, busy;
    logic [1:0] tx_kind;
    pbvt_top #(.CYC_PER_MS(4)) uut (.clock(clock), .rst_n(rst_n), .contact(contact),
        .bus_present(bus_present), .mode_temp(mode_temp), .edge_sel(edge_sel),
        .scene_rise(scene_rise), .scene_fall(scene_fall), .store_only(store_only),
        .store_base(store_base), .store_factor(store_factor), .temp_rise(temp_rise),
        .temp_fall(temp_fall), .adj_en(adj_en), .adj_base(adj_base),
        .adj_factor(adj_factor), .ret_react(ret_react), .ret_delay_ms(ret_delay_ms),
        .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_data(tx_data), .tx_btn(tx_btn),
        .cur_value(cur_value), .busy(busy));
    pbvt_bus_model m (.clock(clock), .rst_n(rst_n), .tx_valid(tx_valid),
        .tx_kind(tx_kind), .tx_data(tx_data), .tx_btn(tx_btn), .bus_present(bus_present));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Bus voltage drops with reset; the log is cleared once start-up settles
    task automatic do_reset();
        rst_n = 1'b0;
        m.bus_set(1'b0);
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        repeat (20) @(negedge clock);
        m.n = 0;
    endtask
    task automatic press(int hold);
        contact = ~contact;
        repeat (hold) @(negedge clock);
        contact = ~contact;
        repeat (30) @(negedge clock);
    endtask
    task automatic exp(int i, logic [1:0] k, logic [DATA_W-1:0] d, logic b);
        `CHK(m.kind[i], k)
        `CHK(m.data[i], d)
        `CHK(m.btn[i], b)
    endtask
    // Delay is 3 ms of 4 cycles, so nothing may come before 12 cycles
    task automatic ret_case(logic md, logic [1:0] r, logic [1:0] e, logic c, int cnt,
        logic [DATA_W-1:0] d);
        mode_temp = md;
        ret_react = r;
        edge_sel = e;
        contact = c;
        do_reset();
        m.bus_set(1'b1);
        repeat (60) @(negedge clock);
        `CHK(m.n, cnt)
        if (cnt > 0) begin
            exp(0, md ? KIND_VALUE : KIND_RECALL, d, 1'b0);
            `CHK((m.at[0] - m.rise_at) inside {[12:24]}, 1'b1)
        end
    endtask
    initial begin
        // About twice the 28k cycles that the sequence below needs
        #400us;
        miscompares++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        contact = 1'b0;
        mode_temp = 1'b0;
        edge_sel = EDGE_RISE;
        scene_rise = 7'h05;
        scene_fall = 7'h09;
        store_only = 1'b0;
        store_base = 2'h1;
        store_factor = 7'h05;
        temp_rise = 7'h19;
        temp_fall = 7'h12;
        adj_en = 1'b0;
        adj_base = 2'h0;
        adj_factor = 7'h01;
        ret_react = RET_NONE;
        ret_delay_ms = 17'h00003;
        do_reset();
        // Factor 5 is raised to 9: 260 ms x 9 x 4 cycles
        press(10000);
        `CHK(m.n, 2)
        exp(0, KIND_RECALL, 7'h05, 1'b1);
        exp(1, KIND_STORE, 7'h05, 1'b1);
        `CHK((m.at[1] - m.at[0]) inside {[9356:9364]}, 1'b1)
        m.n = 0;
        press(100);
        `CHK(m.n, 1)
        `CHK(busy, 1'b0)
        m.n = 0;
        store_only = 1'b1;
        press(10000);
        `CHK(m.n, 1)
        `CHK(busy, 1'b0)
        exp(0, KIND_STORE, 7'h05, 1'b1);
        store_only = 1'b0;
        edge_sel = EDGE_FALL;
        contact = 1'b1;
        do_reset();
        press(100);
        `CHK(m.n, 1)
        exp(0, KIND_RECALL, 7'h09, 1'b1);
        ret_case(1'b0, RET_NONE, EDGE_RISE, 1'b0, 0, 7'h00);
        ret_case(1'b0, RET_RISE, EDGE_RISE, 1'b0, 1, 7'h05);
        ret_case(1'b0, RET_FALL, EDGE_FALL, 1'b1, 1, 7'h09);
        ret_case(1'b0, RET_FALL, EDGE_RISE, 1'b0, 0, 7'h00);
        ret_case(1'b1, RET_RISE, EDGE_RISE, 1'b0, 1, 7'h19);
        ret_case(1'b1, RET_CUR, EDGE_BOTH, 1'b1, 1, 7'h19);
        ret_case(1'b1, RET_CUR, EDGE_BOTH, 1'b0, 1, 7'h12);
        ret_react = RET_NONE;
        edge_sel = EDGE_RISE;
        contact = 1'b0;
        do_reset();
        press(100);
        exp(0, KIND_VALUE, 7'h19, 1'b1);
        edge_sel = EDGE_FALL;
        contact = 1'b1;
        do_reset();
        press(100);
        exp(0, KIND_VALUE, 7'h12, 1'b1);
        edge_sel = EDGE_BOTH;
        contact = 1'b0;
        do_reset();
        press(100);
        `CHK(m.n, 2)
        exp(1, KIND_VALUE, 7'h12, 1'b1);
        edge_sel = EDGE_RISE;
        do_reset();
        press(4000);
        `CHK(m.n, 1)
        // Factor 1 is raised to 3: 130 ms x 3 x 4 cycles per step
        adj_en = 1'b1;
        temp_rise = 7'h0A;
        do_reset();
        press(2500);
        `CHK(m.n, 2)
        exp(1, KIND_VALUE, 7'h09, 1'b1);
        `CHK((m.at[1] - m.at[0]) inside {[1556:1564]}, 1'b1)
        `CHK(cur_value, 7'h09)
        m.n = 0;
        press(100);
        exp(0, KIND_VALUE, 7'h09, 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
